// ### pif_top.v
// Notes on behaviour
// - Flags set on their event regardless of own enable or global enable.
// - Register 1 bits 7..0: gate, converter, receive, transmit, sync, capture1, timer2, timer1.
// - Receive and transmit flags are read-only; other six flags in register 1 writable.
// - Register 2: oscfail, comp2, comp1, none, collision, timer6, timer4, capture2.
// - Register 3: none, numeric osc, shutdown, zero-cross, logic cells 4..1.
// - A flag reads 1 while pending, 0 otherwise.
// - All implemented flags clear to zero on every reset.
// - Unimplemented bits ignore writes and read zero.
// - No request reaches peripheral_irq unless peripheral enable is set; irq follows the masked sticky status bit.
// - Each flag pairs with an enable bit at the same position.
`timescale 1ns/100ps
`include "pif_consts.vh"
module pif_top (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  // Register 1 events
  input wire timer1_gate_flag,
  input wire converter_done_flag,
  input wire serial_receive_flag,
  input wire serial_transmit_flag,
  input wire sync_serial_flag,
  input wire capture_unit1_flag,
  input wire timer2_match_flag,
  input wire timer1_overflow_flag,
  // Register 2 events
  input wire oscillator_fail_flag,
  input wire comparator2_flag,
  input wire comparator1_flag,
  input wire bus_collision_flag,
  input wire timer6_match_flag,
  input wire timer4_match_flag,
  input wire capture_unit2_flag,
  // Register 3 events
  input wire numeric_oscillator_flag,
  input wire output_shutdown_flag,
  input wire zero_cross_flag,
  input wire logic_cell4_flag,
  input wire logic_cell3_flag,
  input wire logic_cell2_flag,
  input wire logic_cell1_flag,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  // Core side
  output reg peripheral_irq,
  output reg irq
);
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire bus_req;
  wire wr_lane0;
  wire [7:0] wr_byte;
  reg [7:0] enable1;
  reg [7:0] enable2;
  reg [7:0] enable3;
  reg [7:0] core_ctrl;
  reg [7:0] irq_status;
  reg [7:0] irq_mask;
  reg req_level;
  wire [7:0] flags1;
  wire [7:0] flags2;
  wire [7:0] flags3;
  wire [7:0] ev1;
  wire [7:0] ev2;
  wire [7:0] ev3;
  wire next_req;
  reg [7:0] next_irq_status;
  reg [31:0] rd_word;
  reg addr_hit;

  function wr_at;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      wr_at = (adr == ofs);
    end
  endfunction

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0] & addr_hit;
  assign wr_byte = wb_dat_i[7:0];

  always @* begin
    addr_hit = 1'b1;
    rd_word = 32'h00000000;
    case (wb_adr_i)
      `PIF_OFS_FLAGS1: rd_word[7:0] = flags1;
      `PIF_OFS_FLAGS2: rd_word[7:0] = flags2;
      `PIF_OFS_FLAGS3: rd_word[7:0] = flags3;
      `PIF_OFS_ENABLE1: rd_word[7:0] = enable1;
      `PIF_OFS_ENABLE2: rd_word[7:0] = enable2;
      `PIF_OFS_ENABLE3: rd_word[7:0] = enable3;
      `PIF_OFS_CORE_CTRL: rd_word[7:0] = core_ctrl;
      `PIF_OFS_IRQ_STATUS: rd_word[7:0] = irq_status;
      `PIF_OFS_IRQ_MASK: rd_word[7:0] = irq_mask;
      default: addr_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Event vectors in register bit order
  // ------------------------------------------------------------
  assign ev1 = {timer1_gate_flag, converter_done_flag, serial_receive_flag, serial_transmit_flag,
                sync_serial_flag, capture_unit1_flag, timer2_match_flag, timer1_overflow_flag};
  assign ev2 = {oscillator_fail_flag, comparator2_flag, comparator1_flag, 1'b0,
                bus_collision_flag, timer6_match_flag, timer4_match_flag, capture_unit2_flag};
  assign ev3 = {1'b0, numeric_oscillator_flag, output_shutdown_flag, zero_cross_flag,
                logic_cell4_flag, logic_cell3_flag, logic_cell2_flag, logic_cell1_flag};

  // ------------------------------------------------------------
  // Flag registers
  // ------------------------------------------------------------
  pif_flag_reg #(.IMPL(`PIF_IMPL1), .SWWR(`PIF_SWWR1)) u_flags1 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .event_in(ev1),
    .wr_en(wr_lane0 & wr_at(wb_adr_i, `PIF_OFS_FLAGS1)),
    .wr_data(wr_byte),
    .flags(flags1)
  );

  pif_flag_reg #(.IMPL(`PIF_IMPL2), .SWWR(`PIF_SWWR2)) u_flags2 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .event_in(ev2),
    .wr_en(wr_lane0 & wr_at(wb_adr_i, `PIF_OFS_FLAGS2)),
    .wr_data(wr_byte),
    .flags(flags2)
  );

  pif_flag_reg #(.IMPL(`PIF_IMPL3), .SWWR(`PIF_SWWR3)) u_flags3 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .event_in(ev3),
    .wr_en(wr_lane0 & wr_at(wb_adr_i, `PIF_OFS_FLAGS3)),
    .wr_data(wr_byte),
    .flags(flags3)
  );

  // ------------------------------------------------------------
  // Request combination
  // ------------------------------------------------------------
  assign next_req = core_ctrl[`PIF_GIE_BIT] & core_ctrl[`PIF_PERIPHERAL_INTERRUPT_ENABLE_BIT] &
                    (|(flags1 & enable1) | |(flags2 & enable2) | |(flags3 & enable3));

  // Rising request sets a sticky status bit; event beats the clear
  always @* begin
    next_irq_status = irq_status;
    if (wr_lane0 && wr_at(wb_adr_i, `PIF_OFS_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~wr_byte;
    end
    if (next_req && !req_level) begin
      next_irq_status[`PIF_IST_REQ_RISE] = 1'b1;
    end
    next_irq_status = next_irq_status & `PIF_IST_MASK;
  end

  // ------------------------------------------------------------
  // Control registers and bus answer
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable1 <= `PIF_RST_BYTE;
      enable2 <= `PIF_RST_BYTE;
      enable3 <= `PIF_RST_BYTE;
      core_ctrl <= `PIF_RST_BYTE;
      irq_status <= `PIF_RST_BYTE;
      irq_mask <= `PIF_RST_BYTE;
      req_level <= 1'b0;
      peripheral_irq <= 1'b0;
      irq <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (clk_en) begin
      wb_ack_o <= bus_req & addr_hit;
      wb_err_o <= bus_req & ~addr_hit;
      wb_dat_o <= (bus_req & ~wb_we_i & addr_hit) ? rd_word : 32'h00000000;
      if (wr_lane0) begin
        if (wr_at(wb_adr_i, `PIF_OFS_ENABLE1)) begin
          enable1 <= wr_byte & `PIF_IMPL1;
        end
        if (wr_at(wb_adr_i, `PIF_OFS_ENABLE2)) begin
          enable2 <= wr_byte & `PIF_IMPL2;
        end
        if (wr_at(wb_adr_i, `PIF_OFS_ENABLE3)) begin
          enable3 <= wr_byte & `PIF_IMPL3;
        end
        if (wr_at(wb_adr_i, `PIF_OFS_CORE_CTRL)) begin
          core_ctrl <= wr_byte & `PIF_CORE_MASK;
        end
        if (wr_at(wb_adr_i, `PIF_OFS_IRQ_MASK)) begin
          irq_mask <= wr_byte & `PIF_IST_MASK;
        end
      end
      irq_status <= next_irq_status;
      req_level <= next_req;
      peripheral_irq <= next_req;
      irq <= |(next_irq_status & irq_mask);
    end
  end
endmodule

// ### pif_consts.vh
`ifndef PIF_CONSTS_VH
`define PIF_CONSTS_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PIF_OFS_FLAGS1 8'h00
`define PIF_OFS_FLAGS2 8'h04
`define PIF_OFS_FLAGS3 8'h08
`define PIF_OFS_ENABLE1 8'h0C
`define PIF_OFS_ENABLE2 8'h10
`define PIF_OFS_ENABLE3 8'h14
`define PIF_OFS_CORE_CTRL 8'h18
`define PIF_OFS_IRQ_STATUS 8'h1C
`define PIF_OFS_IRQ_MASK 8'h20
// ------------------------------------------------------------
// Implemented bits and software-writable bits per register
// ------------------------------------------------------------
`define PIF_IMPL1 8'hFF
`define PIF_IMPL2 8'hEF
`define PIF_IMPL3 8'h7F
`define PIF_SWWR1 8'hCF
`define PIF_SWWR2 8'hEF
`define PIF_SWWR3 8'h7F
// ------------------------------------------------------------
// Core control fields
// ------------------------------------------------------------
`define PIF_GIE_BIT 7
`define PIF_PERIPHERAL_INTERRUPT_ENABLE_BIT 6
`define PIF_CORE_MASK 8'hC0
// ------------------------------------------------------------
// Interrupt status fields
// ------------------------------------------------------------
`define PIF_IST_REQ_RISE 0
`define PIF_IST_MASK 8'h01
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PIF_RST_BYTE 8'h00
`endif

// ### pif_flag_reg.v
`timescale 1ns/100ps
`include "pif_consts.vh"
// ------------------------------------------------------------
// One 8-bit request flag register
// ------------------------------------------------------------
module pif_flag_reg #(
  parameter [7:0] IMPL = 8'hFF,
  parameter [7:0] SWWR = 8'hFF
) (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  input wire [7:0] event_in,
  input wire wr_en,
  input wire [7:0] wr_data,
  output reg [7:0] flags
);
  reg [7:0] next_flags;

  always @* begin
    next_flags = flags;
    if (wr_en) begin
      next_flags = (flags & ~SWWR) | (wr_data & SWWR);
    end
    // Events win over a same-cycle clearing write
    next_flags = (next_flags | event_in) & IMPL;
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= `PIF_RST_BYTE;
    end else if (clk_en) begin
      flags <= next_flags;
    end
  end
endmodule

// ### pif_props.sv
`timescale 1ns/100ps
`include "pif_consts.vh"
module pif_props (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire peripheral_irq,
  input wire irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && clk_en;
  wire mapped = wb_adr_i[1:0] == 2'h0 && wb_adr_i < 8'h24;
  // ------------------------------------------------------------
  // Bus answer
  // ------------------------------------------------------------
  mapped_ack_a: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acknowledged");
  unmapped_err_a: assert property (req && wb_adr_i > 8'h23 |=> wb_err_o && wb_dat_o == 32'h0)
    else $error("unmapped access not refused");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside acknowledge");
  upper_zero_a: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  // ------------------------------------------------------------
  // Register contents
  // ------------------------------------------------------------
  unimpl2_zero_a: assert property (req && !wb_we_i && wb_adr_i == `PIF_OFS_FLAGS2 |=> !wb_dat_o[4])
    else $error("unused bit of second flag register set");
  unimpl3_zero_a: assert property (req && !wb_we_i && wb_adr_i == `PIF_OFS_FLAGS3 |=> !wb_dat_o[7])
    else $error("unused bit of third flag register set");
  reset_quiet_a: assert property ($rose(reset_n) |-> !peripheral_irq && !irq)
    else $error("request active after reset");
  cover property (req && wb_we_i);
  cover property (wb_err_o);
  cover property ($rose(irq));
endmodule

// ### pif_evsrc.sv
`timescale 1ns/100ps
module pif_evsrc (
  input wire core_clk,
  input wire [21:0] fire,
  output logic [21:0] ev
);
  // Peripheral events come out aligned to the core clock
  always @(posedge core_clk) begin
    ev <= fire;
  end
endmodule

// ### tb.sv
`timescale 1ns/100ps
`include "pif_consts.vh"
module tb;
  logic core_clk = 0, reset_n = 0, clk_en = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, r;
  logic [21:0] fire = 0, ev;
  logic [23:0] e = 0;
  logic [8:0] q[$];
  wire [31:0] wb_dat_o;
  wire wb_ack_o, wb_err_o, peripheral_irq, irq;
  int fails = 0, tests_run = 0, cyc_n = 0;
  always #12.5 core_clk = ~core_clk;
  pif_evsrc src (.core_clk, .fire, .ev);
  pif_top dut (.core_clk, .reset_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .peripheral_irq, .irq,
    .timer1_gate_flag(ev[21]), .converter_done_flag(ev[20]), .serial_receive_flag(ev[19]),
    .serial_transmit_flag(ev[18]), .sync_serial_flag(ev[17]), .capture_unit1_flag(ev[16]),
    .timer2_match_flag(ev[15]), .timer1_overflow_flag(ev[14]), .oscillator_fail_flag(ev[13]),
    .comparator2_flag(ev[12]), .comparator1_flag(ev[11]), .bus_collision_flag(ev[10]),
    .timer6_match_flag(ev[9]), .timer4_match_flag(ev[8]), .capture_unit2_flag(ev[7]),
    .numeric_oscillator_flag(ev[6]), .output_shutdown_flag(ev[5]), .zero_cross_flag(ev[4]),
    .logic_cell4_flag(ev[3]), .logic_cell3_flag(ev[2]), .logic_cell2_flag(ev[1]), .logic_cell1_flag(ev[0]));
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(string n, logic [8:0] x, logic [8:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  // ------------------------------------------------------------
  // Bus master; each access notes its expected answer
  // ------------------------------------------------------------
  task bus(logic w, logic [7:0] a, logic [7:0] d, logic [8:0] x);
    q.push_back(x);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) @(posedge core_clk);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge core_clk);
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    bus(1, a, d, 9'h000);
  endtask
  task rd(logic [7:0] a, logic [8:0] x);
    bus(0, a, 8'h00, x);
  endtask
  task rall;
    for (int i = 0; i < 3; i++) rd(8'(4 * i), {1'b0, e[23 - 8 * i -: 8]});
  endtask
  task wall(logic [7:0] d);
    for (int i = 0; i < 3; i++) wr(8'(4 * i), d);
    e = (e & ~24'hCFEF7F) | ({3{d}} & 24'hCFEF7F);
  endtask
  task pulse(logic [21:0] v);
    fire <= v;
    @(posedge core_clk);
    fire <= 22'h0;
    @(posedge core_clk);
    e = e | {v[21:11], 1'b0, v[10:7], 1'b0, v[6:0]};
  endtask
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) chk("bus", q.pop_front(), {wb_err_o, wb_dat_o[7:0]});
    cyc_n++;
    if (cyc_n == 2000) begin
      fails++;
      summarize;
    end
  end
  initial begin
    void'($urandom(32'h99790B3D));
    repeat (3) @(posedge core_clk);
    reset_n <= 1;
    @(posedge core_clk);
    rall;
    rd(8'h24, 9'h100);
    wall(8'hFF);
    rall;
    repeat (4) begin
      r = $urandom;
      pulse(r[21:0]);
      rall;
      wall(8'h00);
      rall;
    end
    // Events while the clock enable is low leave every flag frozen
    clk_en <= 0;
    fire <= 22'h3FFFFF;
    @(posedge core_clk);
    fire <= 22'h0;
    @(posedge core_clk);
    clk_en <= 1;
    @(posedge core_clk);
    rall;
    wall(8'h00);
    wr(`PIF_OFS_ENABLE1, 8'h80);
    wr(`PIF_OFS_CORE_CTRL, 8'hC0);
    chk("pirq", 9'h0, 9'(peripheral_irq));
    fire <= 22'h200000;
    @(posedge core_clk);
    wr(8'h00, 8'h00);
    fire <= 22'h0;
    e[23] = 1'b1;
    rd(8'h00, {1'b0, e[23:16]});
    for (int i = 0; i < 4; i++) begin
      wr(`PIF_OFS_CORE_CTRL, 8'(i << 6));
      chk("pirq", 9'(i == 3), 9'(peripheral_irq));
    end
    wr(`PIF_OFS_ENABLE1, 8'h01);
    chk("pirq", 9'h0, 9'(peripheral_irq));
    rd(`PIF_OFS_IRQ_STATUS, 9'h001);
    chk("irq", 9'h0, 9'(irq));
    wr(`PIF_OFS_IRQ_MASK, 8'h01);
    chk("irq", 9'h1, 9'(irq));
    wr(`PIF_OFS_IRQ_STATUS, 8'h01);
    chk("irq", 9'h0, 9'(irq));
    rd(`PIF_OFS_IRQ_STATUS, 9'h000);
    reset_n <= 0;
    @(posedge core_clk);
    reset_n <= 1;
    @(posedge core_clk);
    e = 24'h0;
    rall;
    summarize;
  end
endmodule
bind pif_top pif_props chk_i (.core_clk, .reset_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .peripheral_irq, .irq);
